// File: nmb_pkg.sv
// Package of constants and types for the narrow memory bus pin control block
package nmb_pkg;
  // Interface input clock source, as strapped at reset
  typedef enum logic [1:0] {
    NMB_CLK_EXT  = 2'h0,
    NMB_CLK_DIV4 = 2'h1,
    NMB_CLK_DIV6 = 2'h2
  } nmb_clk_src_t;

  // Divide factor of the second output clock
  typedef enum logic [1:0] {
    NMB_DIV_1 = 2'h0,
    NMB_DIV_2 = 2'h1,
    NMB_DIV_4 = 2'h2
  } nmb_div_t;

  // Attached memory kind of the current space
  typedef enum logic [1:0] {
    NMB_MEM_ASYNC = 2'h0,
    NMB_MEM_SDRAM = 2'h1,
    NMB_MEM_SYNC  = 2'h2
  } nmb_mem_t;

  // Core clock divider last counts and high phases
  localparam logic [2:0] NMB_DIV4_LAST = 3'h3;
  localparam logic [2:0] NMB_DIV4_HIGH = 3'h2;
  localparam logic [2:0] NMB_DIV6_LAST = 3'h5;
  localparam logic [2:0] NMB_DIV6_HIGH = 3'h3;

  // Fourth chip-select space index, which owns the FIFO output enable
  localparam logic [1:0] NMB_FIFO_SPACE = 2'h3;

  // Pin levels
  localparam logic [1:0] NMB_LANES_IDLE = 2'h3;
  localparam logic [3:0] NMB_CS_IDLE    = 4'hf;
  localparam logic [3:0] NMB_CS_ONE     = 4'h1;
  // Straps default to the external clock until captured
  localparam logic [1:0] NMB_STRAP_RST  = 2'h0;
endpackage

// File: nmb_iface_clk.sv
// Interface clock source selection and the two output clocks
`timescale 1ns/100ps
`default_nettype none
module nmb_iface_clk
  import nmb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] clk_select_straps,
  input  wire logic       iface_ext_clk_in,
  input  wire logic [1:0] clk_div_sel,
  output logic            iface_tick,
  output logic            iface_clk_out_full,
  output logic            iface_clk_out_div
);
  nmb_clk_src_t src_q;       // Source caught after reset
  logic         strap_done_q; // Straps captured flag
  logic [2:0]   cnt_q;       // Core clock divider count
  logic         lvl_d;       // Selected interface clock level
  logic         lvl_q;       // Previous level for edge detect
  logic         div_ph_q;    // Second-edge phase for divide by four
  logic         rise;        // Rising edge of interface clock

  // Straps are sampled by a clocked process after release, not by reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_q        <= nmb_clk_src_t'(NMB_STRAP_RST);
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      src_q        <= nmb_clk_src_t'(clk_select_straps); // R09
      strap_done_q <= 1'b1;
    end
  end

  // Core clock divider, wraps at the selected period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else if ((src_q == NMB_CLK_DIV4 && cnt_q == NMB_DIV4_LAST) ||
                 (src_q == NMB_CLK_DIV6 && cnt_q == NMB_DIV6_LAST)) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Level of the chosen source
  always_comb begin
    case (src_q)
      NMB_CLK_DIV4: lvl_d = (cnt_q < NMB_DIV4_HIGH); // R09
      NMB_CLK_DIV6: lvl_d = (cnt_q < NMB_DIV6_HIGH); // R09
      default:      lvl_d = iface_ext_clk_in;       // R09
    endcase
  end

  assign rise = lvl_d & ~lvl_q;

  // Full-rate output clock follows the selected level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_q              <= 1'b0;
      iface_clk_out_full <= 1'b0;
      iface_tick         <= 1'b0;
    end else begin
      lvl_q              <= lvl_d;
      iface_clk_out_full <= lvl_d; // R11
      iface_tick         <= rise;
    end
  end

  // Divided output clock; toggling on rising edges keeps a clean duty cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      iface_clk_out_div <= 1'b0;
      div_ph_q          <= 1'b0;
    end else begin
      case (nmb_div_t'(clk_div_sel))
        NMB_DIV_2: if (rise) begin
          iface_clk_out_div <= ~iface_clk_out_div; // R10
        end
        NMB_DIV_4: if (rise) begin
          div_ph_q <= ~div_ph_q;
          if (div_ph_q) begin
            iface_clk_out_div <= ~iface_clk_out_div; // R10
          end
        end
        default: iface_clk_out_div <= lvl_d; // R10
      endcase
    end
  end
endmodule
`default_nettype wire

// File: nmb_pin_ctrl.sv
// Pin-level control of the narrow external memory bus: selects, lanes, strobes, hold
//
// Overview of operation
// R01 - One select low per external access
// R02 - Lane enables decode low address, width aware
// R03 - Lanes act as byte write strobes
// R04 - With SDRAM lanes mask reads and writes
// R05 - Peripheral direct transfer strobe output
// R06 - Host holds request while it needs bus
// R07 - Acknowledge host hold request
// R08 - Bus request output shows pending need
// R09 - Straps pick external, quarter or sixth clock
// R10 - Second output clock divides by 1/2/4
// R11 - First output clock at interface rate
// R12 - Shared pin: read, column, address strobes
// R13 - Shared pin: output enable, row strobe
// R14 - Shared pin: write enable for all kinds
// R15 - Select field picks address strobe or read
// R16 - FIFO output enable tied to space three
// R17 - Under hold: float outputs, start nothing
// R18 - Idle bus keeps controls high
`timescale 1ns/100ps
`default_nettype none
module nmb_pin_ctrl
  import nmb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] clk_select_straps,
  input  wire logic       iface_ext_clk_in,
  input  wire logic [1:0] clk_div_sel,
  input  wire logic       req_valid,
  input  wire logic       req_write,
  input  wire logic [1:0] req_space,
  input  wire logic       req_addr0,
  input  wire logic       req_byte,
  input  wire logic       req_periph,
  input  wire logic [1:0] mem_kind,
  input  wire logic       mem_width8,
  input  wire logic       read_en_select,
  input  wire logic       host_hold_req_n,
  output logic            req_ready,
  output logic            req_done,
  output logic            bus_drive_en,
  output logic [3:0]      space_select_n,
  output logic            lane0_enable_n,
  output logic            lane1_enable_n,
  output logic            periph_direct_xfer_n,
  output logic            read_strobe_n,
  output logic            out_strobe_n,
  output logic            write_strobe_n,
  output logic            fifo_out_en_n,
  output logic            host_hold_ack_n,
  output logic            narrow_bus_request,
  output logic            iface_clk_out_full,
  output logic            iface_clk_out_div
);
  // Access sequence states
  typedef enum logic [1:0] {
    NMB_ST_IDLE,
    NMB_ST_SETUP,
    NMB_ST_STROBE,
    NMB_ST_HOLD
  } nmb_state_t;

  nmb_state_t state_q;      // Access state
  logic       tick;         // Interface clock rising edge
  logic       write_q;      // Latched direction
  logic [1:0] space_q;      // Latched space
  logic       addr0_q;      // Latched low address bit
  logic       byte_q;       // Latched byte access flag
  logic       periph_q;     // Latched peripheral transfer flag
  nmb_mem_t   kind_q;       // Latched memory kind
  logic       width8_q;     // Latched memory width
  logic       ren_sel_q;    // Latched read enable select
  logic       hold_req;     // Host request, active high

  // Lane enables for an access, active low
  function automatic logic [1:0] lane_decode(input logic w8, input logic bsel,
                                             input logic a0);
    if (w8) begin
      lane_decode = 2'h2;                    // 8-bit memory uses lane 0 only
    end else if (bsel) begin
      lane_decode = a0 ? 2'h1 : 2'h2;        // Only the addressed byte
    end else begin
      lane_decode = 2'h0;                    // Both bytes of a halfword
    end
  endfunction

  // Chip select pattern for a space, active low
  function automatic logic [3:0] space_decode(input logic [1:0] sp);
    space_decode = ~(NMB_CS_ONE << sp);
  endfunction

  assign hold_req = ~host_hold_req_n; // R06

  // Clock selection and output clocks
  nmb_iface_clk u_clk (
    .clk                (clk),
    .rst_n              (rst_n),
    .clk_select_straps  (clk_select_straps),
    .iface_ext_clk_in   (iface_ext_clk_in),
    .clk_div_sel        (clk_div_sel),
    .iface_tick         (tick),
    .iface_clk_out_full (iface_clk_out_full),
    .iface_clk_out_div  (iface_clk_out_div)
  );

  // Sequencer advances on interface clock edges only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= NMB_ST_IDLE;
    end else if (tick) begin
      case (state_q)
        NMB_ST_IDLE: begin
          if (hold_req) begin
            state_q <= NMB_ST_HOLD; // R07
          end else if (req_valid) begin
            state_q <= NMB_ST_SETUP;
          end
        end
        NMB_ST_SETUP:  state_q <= NMB_ST_STROBE;
        NMB_ST_STROBE: state_q <= NMB_ST_IDLE;
        NMB_ST_HOLD: begin
          if (!hold_req) begin
            state_q <= NMB_ST_IDLE; // R17
          end
        end
        default: state_q <= NMB_ST_IDLE;
      endcase
    end
  end

  // Access attributes captured as the request is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_q   <= 1'b0;
      space_q   <= 2'h0;
      addr0_q   <= 1'b0;
      byte_q    <= 1'b0;
      periph_q  <= 1'b0;
      kind_q    <= NMB_MEM_ASYNC;
      width8_q  <= 1'b0;
      ren_sel_q <= 1'b0;
    end else if (tick && state_q == NMB_ST_IDLE && !hold_req && req_valid) begin
      write_q   <= req_write;
      space_q   <= req_space;
      addr0_q   <= req_addr0;
      byte_q    <= req_byte;
      periph_q  <= req_periph;
      kind_q    <= nmb_mem_t'(mem_kind);
      width8_q  <= mem_width8;
      ren_sel_q <= read_en_select;
    end
  end

  // Handshake with the core; a request is only taken outside hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
      req_done  <= 1'b0;
    end else begin
      req_ready <= tick && state_q == NMB_ST_IDLE && !hold_req && req_valid; // R17
      req_done  <= tick && state_q == NMB_ST_STROBE;
    end
  end

  // Arbitration outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_hold_ack_n    <= 1'b1;
      narrow_bus_request <= 1'b0;
    end else begin
      host_hold_ack_n    <= state_q != NMB_ST_HOLD; // R07
      narrow_bus_request <= req_valid || (state_q == NMB_ST_SETUP) ||
                            (state_q == NMB_ST_STROBE); // R08
    end
  end

  // Drive enable drops in hold so the host may own the pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_drive_en <= 1'b0;
    end else begin
      bus_drive_en <= state_q != NMB_ST_HOLD; // R17
    end
  end

  // Select, lane and transfer pins held for the whole access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      space_select_n       <= NMB_CS_IDLE;
      lane0_enable_n       <= 1'b1;
      lane1_enable_n       <= 1'b1;
      periph_direct_xfer_n <= 1'b1;
    end else if (state_q == NMB_ST_SETUP || state_q == NMB_ST_STROBE) begin
      space_select_n       <= space_decode(space_q); // R01
      periph_direct_xfer_n <= ~periph_q; // R05
      if (kind_q == NMB_MEM_SDRAM || write_q) begin
        // SDRAM mask covers reads too; others strobe bytes on writes
        {lane1_enable_n, lane0_enable_n} <= lane_decode(width8_q, byte_q, addr0_q); // R02 R03 R04
      end else begin
        {lane1_enable_n, lane0_enable_n} <= NMB_LANES_IDLE;
      end
    end else begin
      space_select_n       <= NMB_CS_IDLE; // R18
      lane0_enable_n       <= 1'b1; // R18
      lane1_enable_n       <= 1'b1; // R18
      periph_direct_xfer_n <= 1'b1; // R18
    end
  end

  // Shared strobe pins; their role follows the memory kind of the space
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      read_strobe_n  <= 1'b1;
      out_strobe_n   <= 1'b1;
      write_strobe_n <= 1'b1;
      fifo_out_en_n  <= 1'b1;
    end else begin
      read_strobe_n  <= 1'b1; // R18
      out_strobe_n   <= 1'b1; // R18
      write_strobe_n <= 1'b1; // R18
      fifo_out_en_n  <= 1'b1; // R18
      case (state_q)
        NMB_ST_SETUP: begin
          if (kind_q == NMB_MEM_SDRAM) begin
            out_strobe_n <= 1'b0; // R13
          end
        end
        NMB_ST_STROBE: begin
          case (kind_q)
            NMB_MEM_SDRAM: begin
              read_strobe_n  <= 1'b0; // R12
              write_strobe_n <= ~write_q; // R14
            end
            NMB_MEM_SYNC: begin
              // Address strobe marks every access; read enable only reads
              read_strobe_n  <= ren_sel_q ? write_q : 1'b0; // R12 R15
              out_strobe_n   <= write_q; // R13
              write_strobe_n <= ~write_q; // R14
            end
            default: begin
              read_strobe_n  <= write_q; // R12
              out_strobe_n   <= write_q; // R13
              write_strobe_n <= ~write_q; // R14
              fifo_out_en_n  <= write_q || (space_q != NMB_FIFO_SPACE); // R16
            end
          endcase
        end
        default: begin
          fifo_out_en_n <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: nmb_host_model.sv
// Far-side model: bus-requesting host and free-running external clock
`timescale 1ns/100ps
`default_nettype none
module nmb_host_model (
  input  wire logic clk,
  input  wire logic want,
  output logic      host_hold_req_n,
  output logic      iface_ext_clk_in
);
  logic [1:0] cnt_q;  // Half-period counter of the external clock

  // One process owns every model output, so each has a single driver
  initial begin
    cnt_q            = 2'h0;
    iface_ext_clk_in = 1'b0;
    host_hold_req_n  = 1'b1;
    forever begin
      @(posedge clk);
      // Request stays low for as long as the bus is wanted
      host_hold_req_n <= !want;
      // External clock runs free, period of six core cycles
      cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      if (cnt_q == 2'h2) begin
        iface_ext_clk_in <= !iface_ext_clk_in;
      end
    end
  end
endmodule
`default_nettype wire

// File: nmb_pin_ctrl_props.sv
// Checker for the pins of the narrow memory bus pin control block
`timescale 1ns/100ps
`default_nettype none
module nmb_pin_ctrl_props
  import nmb_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       req_valid,
  input wire logic       host_hold_req_n,
  input wire logic       req_ready,
  input wire logic       req_done,
  input wire logic       bus_drive_en,
  input wire logic [3:0] space_select_n,
  input wire logic       lane0_enable_n,
  input wire logic       lane1_enable_n,
  input wire logic       read_strobe_n,
  input wire logic       out_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       fifo_out_en_n,
  input wire logic       host_hold_ack_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // An access must finish; slowest tick is six cycles
  sequence s_take; req_ready; endsequence
  sequence s_end; ##[2:300] req_done; endsequence
  property p_access; s_take |-> s_end; endproperty
  property p_onesel; space_select_n != NMB_CS_IDLE |-> $onehot(~space_select_n); endproperty
  property p_idle; req_done |=> space_select_n == NMB_CS_IDLE && lane0_enable_n
    && lane1_enable_n && read_strobe_n && out_strobe_n && write_strobe_n; endproperty
  property p_float; !host_hold_ack_n |-> !bus_drive_en && space_select_n == NMB_CS_IDLE;
  endproperty
  property p_nostart; !host_hold_ack_n |-> !req_ready; endproperty
  // Ack may only fall shortly after the host asked
  property p_ack; $fell(host_hold_ack_n) |-> !$past(host_hold_req_n)
    || !$past(host_hold_req_n, 2) || !$past(host_hold_req_n, 3); endproperty
  property p_wrlane; !write_strobe_n |-> !(lane0_enable_n && lane1_enable_n); endproperty
  // Column strobe alone marks an SDRAM read
  property p_mask; !read_strobe_n && out_strobe_n && write_strobe_n
    |-> !(lane0_enable_n && lane1_enable_n); endproperty
  property p_fifo; !fifo_out_en_n |-> !space_select_n[3]; endproperty
  a_access: assert property (p_access) else $error("access never ended");
  a_onesel: assert property (p_onesel) else $error("select not one-hot");
  a_idle: assert property (p_idle) else $error("pins not idle high");
  a_float: assert property (p_float) else $error("bus driven in hold");
  a_nostart: assert property (p_nostart) else $error("start in hold");
  a_ack: assert property (p_ack) else $error("ack without request");
  a_wrlane: assert property (p_wrlane) else $error("write without lanes");
  a_mask: assert property (p_mask) else $error("sdram read unmasked");
  a_fifo: assert property (p_fifo) else $error("fifo enable off space");
endmodule
bind nmb_pin_ctrl nmb_pin_ctrl_props i_nmb_pin_ctrl_props (.clk, .rst_n, .req_valid,
  .host_hold_req_n, .req_ready, .req_done, .bus_drive_en, .space_select_n,
  .lane0_enable_n, .lane1_enable_n, .read_strobe_n, .out_strobe_n, .write_strobe_n,
  .fifo_out_en_n, .host_hold_ack_n);
`default_nettype wire

// File: narrow_memory_bus_pin_control_tb.sv
// Self-checking bench of the narrow memory bus pin control block
`timescale 1ns/100ps
`default_nettype none
module narrow_memory_bus_pin_control_tb
  import nmb_pkg::*;
;
  logic clk, rst_n, iface_ext_clk_in, req_valid, req_write, req_addr0, req_byte;
  logic req_periph, mem_width8, read_en_select, host_hold_req_n, want;
  logic [1:0] clk_select_straps, clk_div_sel, req_space, mem_kind;
  logic req_ready, req_done, bus_drive_en, lane0_enable_n, lane1_enable_n;
  logic periph_direct_xfer_n, read_strobe_n, out_strobe_n, write_strobe_n;
  logic fifo_out_en_n, host_hold_ack_n, narrow_bus_request;
  logic iface_clk_out_full, iface_clk_out_div;
  logic [3:0] space_select_n;
  int fails, tests_run;
  // All access pins in one word, selects on top
  wire logic [10:0] pins = {space_select_n, lane1_enable_n, lane0_enable_n,
    read_strobe_n, out_strobe_n, write_strobe_n, fifo_out_en_n, periph_direct_xfer_n};

  nmb_pin_ctrl i_nmb_pin_ctrl (.clk, .rst_n, .clk_select_straps, .iface_ext_clk_in,
    .clk_div_sel, .req_valid, .req_write, .req_space, .req_addr0, .req_byte,
    .req_periph, .mem_kind, .mem_width8, .read_en_select, .host_hold_req_n,
    .req_ready, .req_done, .bus_drive_en, .space_select_n, .lane0_enable_n,
    .lane1_enable_n, .periph_direct_xfer_n, .read_strobe_n, .out_strobe_n,
    .write_strobe_n, .fifo_out_en_n, .host_hold_ack_n, .narrow_bus_request,
    .iface_clk_out_full, .iface_clk_out_div);
  nmb_host_model i_nmb_host_model (.clk, .want, .host_hold_req_n, .iface_ext_clk_in);

  // Core clock, 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end

  // Inputs always move 1 ns after the edge
  task automatic tk(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang(string nm);
    fails++;
    $display("MISMATCH %s expected pulse seen timeout", nm);
    give_verdict();
  endtask
  // Straps are only caught after a reset
  task automatic do_reset(logic [1:0] s);
    rst_n = 1'b0;
    clk_select_straps = s;
    tk(5);
    rst_n = 1'b1;
    tk(2);
  endtask
  // Toggles of both output clocks over 24 cycles, phase independent
  task automatic clk_rate(logic [1:0] s, logic [1:0] d, int ef, int ed);
    int nf, nd;
    logic pf, pd;
    nf = 0;
    nd = 0;
    do_reset(s);
    clk_div_sel = d;
    tk(40);
    pf = iface_clk_out_full;
    pd = iface_clk_out_div;
    repeat (24) begin
      tk();
      nf += int'(iface_clk_out_full !== pf);
      nd += int'(iface_clk_out_div !== pd);
      pf = iface_clk_out_full;
      pd = iface_clk_out_div;
    end
    chk("full_toggles", 16'(nf), 16'(ef));
    chk("div_toggles", 16'(nd), 16'(ed));
  endtask
  // One access; the lowest level each pin reached is compared
  task automatic acc(logic w, logic [1:0] sp, logic a0, logic b, logic p,
                     logic [1:0] k, logic n8, logic re);
    logic [10:0] seen, exp;
    logic ln, sd;
    int i;
    sd = (k == NMB_MEM_SDRAM);
    ln = w | sd;
    // Only the addressed space goes low
    exp = '1;
    exp[7 + sp] = 1'b0;
    exp[6] = !(ln && !n8 && (!b || a0));
    exp[5] = !(ln && (n8 || !b || !a0));
    exp[4] = !((k == NMB_MEM_SYNC) ? (!re || !w) : (sd || !w));
    exp[3] = !(sd || !w);
    exp[2] = !w;
    exp[1] = !(!w && !sd && k != NMB_MEM_SYNC && sp == NMB_FIFO_SPACE);
    exp[0] = !p;
    {req_write, req_space, req_addr0, req_byte, req_periph} = {w, sp, a0, b, p};
    {mem_kind, mem_width8, read_en_select} = {k, n8, re};
    req_valid = 1'b1;
    seen = '1;
    for (i = 0; i < 600 && req_ready !== 1'b1; i++) tk();
    if (req_ready !== 1'b1) hang("req_ready");
    req_valid = 1'b0;
    for (i = 0; i < 300 && req_done !== 1'b1; i++) begin
      seen &= pins;
      tk();
    end
    if (req_done !== 1'b1) hang("req_done");
    seen &= pins;
    chk("pins", 16'(seen), 16'(exp));
  endtask
  // Host takes the idle bus, a request waits through the hold, then the bus is given back
  task automatic hold_test;
    int i;
    want = 1'b1;
    for (i = 0; i < 300 && host_hold_ack_n !== 1'b0; i++) tk();
    if (host_hold_ack_n !== 1'b0) hang("hold_ack");
    chk("hold_ack", 16'(host_hold_ack_n), 16'h0);
    chk("drive_en", 16'(bus_drive_en), 16'h0);
    chk("bus_idle", 16'(narrow_bus_request), 16'h0);
    req_valid = 1'b1;
    tk(30);
    chk("bus_req", 16'(narrow_bus_request), 16'h1);
    want = 1'b0;
    acc(1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    chk("hold_rel", 16'(host_hold_ack_n), 16'h1);
  endtask

  initial begin
    {fails, tests_run} = '0;
    {req_valid, req_write, req_addr0, req_byte, req_periph, want} = '0;
    {mem_width8, read_en_select, req_space, mem_kind, clk_div_sel} = '0;
    clk_rate(2'h0, 2'h0, 8, 8);
    clk_rate(2'h1, 2'h0, 12, 12);
    clk_rate(2'h1, 2'h1, 12, 6);
    clk_rate(2'h1, 2'h2, 12, 3);
    clk_rate(2'h1, 2'h3, 12, 12);
    clk_rate(2'h2, 2'h1, 8, 4);
    clk_rate(2'h3, 2'h2, 8, 2);
    do_reset(2'h1);
    // Back-to-back accesses over every kind, width and lane case
    acc(1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    acc(1'b1, 2'h1, 1'b1, 1'b1, 1'b1, 2'h0, 1'b0, 1'b0);
    acc(1'b1, 2'h2, 1'b0, 1'b1, 1'b0, 2'h0, 1'b0, 1'b0);
    acc(1'b0, 2'h3, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
    acc(1'b1, 2'h3, 1'b0, 1'b0, 1'b0, 2'h3, 1'b1, 1'b0);
    acc(1'b0, 2'h2, 1'b0, 1'b0, 1'b0, 2'h1, 1'b0, 1'b0);
    acc(1'b1, 2'h1, 1'b0, 1'b1, 1'b0, 2'h1, 1'b0, 1'b0);
    acc(1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0);
    acc(1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0);
    acc(1'b0, 2'h1, 1'b0, 1'b0, 1'b1, 2'h2, 1'b0, 1'b1);
    acc(1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1);
    hold_test();
    give_verdict();
  end
endmodule
`default_nettype wire
